// *** hw/mrs_ontime.sv ***
// On-time generator for the high-side switch
// Assumes set requests and on-time counts come from the sequencer
module mrs_ontime (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic clk_en,
  // Sequencer side
  mrs_pwm_if.gen    pwm
);

  logic [7:0] cnt_q;
  logic       on_q;

  // Start an on-cycle on a set request, end when the count runs out
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_q <= 8'h00;
      on_q  <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!pwm.run)
      begin
        cnt_q <= 8'h00;
        on_q  <= 1'b0;
      end
      else if (on_q)
      begin
        if (cnt_q <= 8'h01)
          on_q <= 1'b0;
        cnt_q <= cnt_q - 8'h01;
      end
      else if (pwm.set_req)
      begin
        on_q  <= 1'b1;
        cnt_q <= pwm.on_cycles;
      end
    end
  end

  assign pwm.high_on = on_q;

endmodule

// *** hw/mrs_pkg.sv ***
// Package for the memory rail state sequencer
// Assumes a 10 MHz core clock; all delays are counted in core cycles
package mrs_pkg;

  // Clock period in nanoseconds
  localparam int unsigned CLK_PERIOD_NS = 100;

  // Start-up hold-off before switching, microseconds
  localparam int unsigned HOLDOFF_US     = 400;
  localparam int unsigned HOLDOFF_CYC    = HOLDOFF_US * 1000 / CLK_PERIOD_NS;
  // Typical soft-start ramp, microseconds
  localparam int unsigned RAMP_US        = 700;
  localparam int unsigned RAMP_CYC       = RAMP_US * 1000 / CLK_PERIOD_NS;
  // Rail-good assertion delay, microseconds
  localparam int unsigned GOOD_DLY_US    = 1000;
  localparam int unsigned GOOD_DLY_CYC   = GOOD_DLY_US * 1000 / CLK_PERIOD_NS;
  // Rail-good drop delay, nanoseconds (longest time, rounded down)
  localparam int unsigned BAD_DLY_NS     = 330;
  localparam int unsigned BAD_DLY_CYC    = BAD_DLY_NS / CLK_PERIOD_NS;
  // Comparator enable after fixed reference rises, microseconds
  localparam int unsigned CMP_EN_US      = 1100;
  localparam int unsigned CMP_EN_CYC     = CMP_EN_US * 1000 / CLK_PERIOD_NS;
  // Tracking discharge duration, microseconds
  localparam int unsigned TRACK_US       = 4000;
  localparam int unsigned TRACK_CYC      = TRACK_US * 1000 / CLK_PERIOD_NS;

  // Width of the shared delay counter
  localparam int unsigned CNT_W          = 16;
  // Width of the soft-start reference code
  localparam int unsigned REF_W          = 10;
  localparam logic [REF_W-1:0] REF_FULL  = 10'h3_ff;

  // Option codes decoded from the sense pin level
  localparam logic [1:0] OPT_47K         = 2'h0;
  localparam logic [1:0] OPT_68K         = 2'h1;
  localparam logic [1:0] OPT_100K        = 2'h2;
  localparam logic [1:0] OPT_200K        = 2'h3;
  localparam logic [1:0] OPT_RESET       = 2'h0;

  // Sequencer states
  typedef enum logic [2:0] {
    MRS_OFF,
    MRS_HOLDOFF,
    MRS_RAMP,
    MRS_RUN,
    MRS_DIS_TRACK,
    MRS_DIS_NONTRACK
  } mrs_state_t;

  // Option decode: bit 1 is 400 kHz, bit 0 is tracking discharge
  function automatic logic [1:0] mrs_decode(input logic [1:0] code);
    case (code)
      OPT_200K: mrs_decode = 2'h3;
      OPT_100K: mrs_decode = 2'h1;
      OPT_68K:  mrs_decode = 2'h0;
      default:  mrs_decode = 2'h2;
    endcase
  endfunction

endpackage

// *** hw/mrs_pwm_if.sv ***
// Carrier between the sequencer and its on-time generator
// Assumes one clock domain shared by both ends
interface mrs_pwm_if;
  logic       run;
  logic       set_req;
  logic [7:0] on_cycles;
  logic       high_on;

  modport seq (output run, output set_req, output on_cycles, input high_on);
  modport gen (input run, input set_req, input on_cycles, output high_on);
endinterface

// *** hw/mrs_seq.sv ***
// Memory rail state sequencer: state pins to rail enables and discharge
// Assumes pins asynchronous to core_clk; analog comparators given as levels
// Operation
// - Both selects high: main, term reference, term rail, fixed ref on
// - Suspend low, power-on high: termination rail floats, others on
// - Both low: all off, discharged per latched option
// - Wait 400 us after power-on rises, then ramp reference up
// - Soft-start ramp of main rail takes 700 us
// - Sense option pin through hold-off after power-on rises, latch decoded option at its end
// - Decode option to frequency and tracking or non-tracking discharge
// - Rail-good rises after 1 ms within the 8 percent window
// - Rail-good drops 330 ns after leaving the 16 percent window
// - Rail-good comparator enabled 1.1 ms after fixed reference rises
// - Tracking discharge drains main rail via termination regulator
// - After 4 ms tracking, switch to non-tracking discharge
// - Non-tracking discharge pulls down main and termination rails
// - Issue set request when feedback falls below reference
// - On-time inversely follows input voltage, follows output voltage
module mrs_seq (
  // Clock, reset, enable
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  input  wire logic             clk_en,
  // State pins from the power manager
  input  wire logic             suspend_select,
  input  wire logic             power_on_select,
  // Option pin level code, sampled while sensing
  input  wire logic [1:0]       option_level,
  // Analog comparator levels
  input  wire logic             in_win8,
  input  wire logic             in_win16,
  input  wire logic             fb_below_ref,
  // Input and output voltage codes for on-time
  input  wire logic [7:0]       vin_code,
  input  wire logic [7:0]       vout_code,
  // Rail enables
  output logic                  fixed_ref_en,
  output logic                  main_rail_en,
  output logic                  term_ref_en,
  output logic                  term_rail_en,
  // Discharge controls
  output logic                  track_dis_en,
  output logic                  main_pd_en,
  output logic                  term_pd_en,
  // Option sensing and configuration
  output logic                  sense_src_en,
  output logic                  freq_400k,
  // Soft-start reference and switch drive
  output logic [mrs_pkg::REF_W-1:0] ref_code,
  output logic                  high_side_on,
  // Open-drain rail good: drive low when enabled
  output logic                  rail_good_o,
  output logic                  rail_good_oe
);

  // Synchronised pins
  logic [1:0] sus_sq, pon_sq, w8_sq, w16_sq, fb_sq;
  logic       sus, pon, w8, w16, fb;

  mrs_pkg::mrs_state_t         state_q;
  logic [mrs_pkg::CNT_W-1:0]   cnt_q;
  logic [mrs_pkg::CNT_W-1:0]   cmp_cnt_q;
  logic [mrs_pkg::CNT_W-1:0]   good_cnt_q;
  logic [1:0]                  opt_q;
  logic                        pon_prev_q;
  logic                        good_q;
  logic [7:0]                  on_cyc;
  logic                        pon_rise;
  mrs_pwm_if pwm ();
  // Two-flop synchronisers for the state pins and comparator levels
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sus_sq <= 2'h0;
      pon_sq <= 2'h0;
      w8_sq  <= 2'h0;
      w16_sq <= 2'h0;
      fb_sq  <= 2'h0;
    end
    else if (clk_en)
    begin
      sus_sq <= {sus_sq[0], suspend_select};
      pon_sq <= {pon_sq[0], power_on_select};
      w8_sq  <= {w8_sq[0], in_win8};
      w16_sq <= {w16_sq[0], in_win16};
      fb_sq  <= {fb_sq[0], fb_below_ref};
    end
  end
  assign sus = sus_sq[1];
  assign pon = pon_sq[1];
  assign w8  = w8_sq[1];
  assign w16 = w16_sq[1];
  assign fb  = fb_sq[1];
  // Power-on edge detect
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      pon_prev_q <= 1'b0;
    else if (clk_en)
      pon_prev_q <= pon;
  end
  assign pon_rise = pon && !pon_prev_q;
  // Option latch during hold-off
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      opt_q <= mrs_pkg::OPT_RESET;
    else if (clk_en && state_q == mrs_pkg::MRS_HOLDOFF
             && cnt_q == 16'(mrs_pkg::HOLDOFF_CYC - 1))
      opt_q <= mrs_pkg::mrs_decode(option_level);
  end

  // Main sequencer
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= mrs_pkg::MRS_OFF;
      cnt_q   <= '0;
    end
    else if (clk_en)
    begin
      if (!pon)
      begin
        case (state_q)
          mrs_pkg::MRS_OFF,
          mrs_pkg::MRS_DIS_NONTRACK:
            cnt_q <= '0;
          mrs_pkg::MRS_DIS_TRACK:
          begin
            if (cnt_q == 16'(mrs_pkg::TRACK_CYC - 1))
            begin
              state_q <= mrs_pkg::MRS_DIS_NONTRACK;
              cnt_q   <= '0;
            end
            else
              cnt_q <= cnt_q + 16'h0001;
          end
          default:
          begin
            state_q <= opt_q[0] ? mrs_pkg::MRS_DIS_TRACK
                                : mrs_pkg::MRS_DIS_NONTRACK;
            cnt_q   <= '0;
          end
        endcase
      end
      else
      begin
        case (state_q)
          mrs_pkg::MRS_HOLDOFF:
          begin
            if (cnt_q == 16'(mrs_pkg::HOLDOFF_CYC - 1))
            begin
              state_q <= mrs_pkg::MRS_RAMP;
              cnt_q   <= '0;
            end
            else
              cnt_q <= cnt_q + 16'h0001;
          end
          mrs_pkg::MRS_RAMP:
          begin
            if (cnt_q == 16'(mrs_pkg::RAMP_CYC - 1))
            begin
              state_q <= mrs_pkg::MRS_RUN;
              cnt_q   <= '0;
            end
            else
              cnt_q <= cnt_q + 16'h0001;
          end
          mrs_pkg::MRS_RUN:
            cnt_q <= '0;
          default:
          begin
            if (pon_rise)
            begin
              state_q <= mrs_pkg::MRS_HOLDOFF;
              cnt_q   <= '0;
            end
          end
        endcase
      end
    end
  end

  always_comb
  begin
    case (state_q)
      mrs_pkg::MRS_RAMP:
        ref_code = 10'((32'(cnt_q) * 32'(mrs_pkg::REF_FULL))
                       / mrs_pkg::RAMP_CYC);
      mrs_pkg::MRS_RUN:
        ref_code = mrs_pkg::REF_FULL;
      default:
        ref_code = '0;
    endcase
  end

  assign fixed_ref_en = pon;
  assign term_ref_en  = pon;
  assign main_rail_en = pon && (state_q == mrs_pkg::MRS_RAMP
                                || state_q == mrs_pkg::MRS_RUN);
  assign term_rail_en = pon && sus;
  assign sense_src_en = state_q == mrs_pkg::MRS_HOLDOFF;
  assign freq_400k    = opt_q[1];

  assign track_dis_en = state_q == mrs_pkg::MRS_DIS_TRACK;
  assign main_pd_en   = state_q == mrs_pkg::MRS_DIS_NONTRACK;
  assign term_pd_en   = state_q == mrs_pkg::MRS_DIS_NONTRACK;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      cmp_cnt_q <= '0;
    else if (clk_en)
    begin
      if (!pon)
        cmp_cnt_q <= '0;
      else if (cmp_cnt_q != 16'(mrs_pkg::CMP_EN_CYC))
        cmp_cnt_q <= cmp_cnt_q + 16'h0001;
    end
  end

  // Rail-good qualify and drop
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      good_q     <= 1'b0;
      good_cnt_q <= '0;
    end
    else if (clk_en)
    begin
      if (cmp_cnt_q != 16'(mrs_pkg::CMP_EN_CYC))
      begin
        good_q     <= 1'b0;
        good_cnt_q <= '0;
      end
      else if (!good_q)
      begin
        if (!w8)
          good_cnt_q <= '0;
        else if (good_cnt_q == 16'(mrs_pkg::GOOD_DLY_CYC - 1))
        begin
          good_q     <= 1'b1;
          good_cnt_q <= '0;
        end
        else
          good_cnt_q <= good_cnt_q + 16'h0001;
      end
      else
      begin
        if (w16)
          good_cnt_q <= '0;
        else if (good_cnt_q == 16'(mrs_pkg::BAD_DLY_CYC - 1))
        begin
          good_q     <= 1'b0;
          good_cnt_q <= '0;
        end
        else
          good_cnt_q <= good_cnt_q + 16'h0001;
      end
    end
  end

  assign rail_good_o  = 1'b0;
  assign rail_good_oe = !good_q;

  always_comb
  begin
    if (vin_code == 8'h00)
      on_cyc = 8'hff;
    else
      on_cyc = 8'((16'(vout_code) * 16'h0040) / 16'(vin_code));
  end

  assign pwm.run       = main_rail_en;
  assign pwm.set_req   = fb;
  assign pwm.on_cycles = (on_cyc == 8'h00) ? 8'h01 : on_cyc;

  mrs_ontime u_ontime (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .pwm      (pwm)
  );

  assign high_side_on = pwm.high_on;

endmodule

// *** tb/mrs_pmc_model.sv ***
// Power manager model driving the two state pins
// Assumes the bench requests a state code, bit 1 power-on, bit 0 suspend
module mrs_pmc_model (
  // Clock
  input wire logic       core_clk,
  // Requested state
  input wire logic [1:0] state_req,
  // State pins
  output logic           suspend_select = 1'b0,
  output logic           power_on_select = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pins move just after the edge and hold until the next request
  always @(posedge core_clk)
  begin
    power_on_select <= #2 state_req[1];
    suspend_select  <= #2 state_req[0];
  end
endmodule

// *** tb/mrs_seq_bench.sv ***
// Self-checking bench for the rail state sequencer
// Assumes a 10 MHz core clock and the power manager model
`define CHK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("wrong value at %0t: %h vs %h", $time, got, exp); \
    end \
  end

module mrs_seq_bench;
  timeunit 1ns;
  timeprecision 1ns;
  int mismatches = 0;
  int total_checks = 0;
  logic core_clk = 0, rst_b = 0;
  logic [1:0] state_req = 0, option_level = 0;
  logic in_win8 = 0, in_win16 = 0, fb_below_ref = 0;
  wire logic suspend_select, power_on_select, fixed_ref_en, main_rail_en;
  wire logic term_ref_en, term_rail_en, track_dis_en, main_pd_en;
  wire logic term_pd_en, sense_src_en, freq_400k, high_side_on;
  wire logic rail_good_o, rail_good_oe;
  wire logic [mrs_pkg::REF_W-1:0] ref_code;

  mrs_pmc_model u_mrs_pmc_model (.core_clk(core_clk),
    .state_req(state_req), .suspend_select(suspend_select),
    .power_on_select(power_on_select));
  mrs_seq u_mrs_seq (.core_clk(core_clk), .rst_b(rst_b), .clk_en(1'b1),
    .suspend_select(suspend_select), .power_on_select(power_on_select),
    .option_level(option_level), .in_win8(in_win8), .in_win16(in_win16),
    .fb_below_ref(fb_below_ref), .vin_code(8'h80), .vout_code(8'h40),
    .fixed_ref_en(fixed_ref_en), .main_rail_en(main_rail_en),
    .term_ref_en(term_ref_en), .term_rail_en(term_rail_en),
    .track_dis_en(track_dis_en), .main_pd_en(main_pd_en),
    .term_pd_en(term_pd_en), .sense_src_en(sense_src_en),
    .freq_400k(freq_400k), .ref_code(ref_code),
    .high_side_on(high_side_on), .rail_good_o(rail_good_o),
    .rail_good_oe(rail_good_oe));

  // Clock at 100 ns period
  initial
  begin
    forever #50 core_clk = ~core_clk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #5;
  endtask

  task automatic complete_run;
    if (mismatches == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Start-up from both selects high through rail good
  task automatic t_full_on;
    option_level = 2'h3;
    in_win8 = 1;
    in_win16 = 1;
    state_req = 2'h3;
    step(6);
    `CHK({fixed_ref_en, term_ref_en, term_rail_en}, 3'h7)
    `CHK(sense_src_en, 1'b1)
    step(3984);
    `CHK(main_rail_en, 1'b0)
    step(30);
    `CHK(main_rail_en, 1'b1)
    step(7100);
    `CHK(ref_code, 10'h3_ff)
    `CHK(freq_400k, 1'b1)
    step(9780);
    `CHK(rail_good_oe, 1'b1)
    step(250);
    `CHK({rail_good_oe, rail_good_o}, 2'h0)
  endtask

  // Set request and on-time width
  task automatic t_set_req;
    int n;
    fb_below_ref = 1;
    n = 0;
    while (high_side_on !== 1'b1 && n < 40)
    begin
      step(1);
      n++;
    end
    `CHK(high_side_on, 1'b1)
    n = 0;
    while (high_side_on === 1'b1 && n < 300)
    begin
      step(1);
      n++;
    end
    fb_below_ref = 0;
    `CHK(n, 32)
  endtask

  // Window loss, suspend, then off with tracking discharge
  task automatic t_states;
    in_win16 = 0;
    step(10);
    `CHK(rail_good_oe, 1'b1)
    in_win16 = 1;
    state_req = 2'h2;
    step(6);
    `CHK({main_rail_en, term_ref_en, term_rail_en}, 3'h6)
    state_req = 2'h0;
    step(6);
    `CHK({fixed_ref_en, main_rail_en, term_ref_en}, 3'h0)
    `CHK({track_dis_en, main_pd_en}, 2'h2)
    step(39980);
    `CHK(track_dis_en, 1'b1)
    step(40);
    `CHK({track_dis_en, main_pd_en, term_pd_en}, 3'h3)
    state_req = 2'h1;
    step(6);
    `CHK({fixed_ref_en, main_rail_en, term_rail_en}, 3'h0)
  endtask

  // Remaining option codes: frequency and discharge kind
  task automatic t_modes;
    logic [2:0] f_exp = 3'h1;
    logic [2:0] t_exp = 3'h4;
    for (int i = 0; i < 3; i++)
    begin
      option_level = i[1:0];
      state_req = 2'h3;
      step(4030);
      `CHK(freq_400k, f_exp[i])
      state_req = 2'h0;
      step(6);
      `CHK({track_dis_en, main_pd_en}, {t_exp[i], ~t_exp[i]})
    end
  endtask

  // Main sequence
  initial
  begin
    step(12);
    `CHK({main_rail_en, fixed_ref_en, rail_good_oe}, 3'h1)
    rst_b = 1;
    step(1);
    t_full_on();
    t_set_req();
    t_states();
    t_modes();
    complete_run();
  end

  // Watchdog
  initial
  begin
    repeat (90000) @(posedge core_clk);
    mismatches++;
    complete_run();
  end
endmodule

bind mrs_seq mrs_seq_properties u_mrs_seq_properties (
  .core_clk(core_clk), .rst_b(rst_b), .suspend_select(suspend_select),
  .power_on_select(power_on_select), .in_win8(in_win8),
  .in_win16(in_win16), .fb_below_ref(fb_below_ref),
  .fixed_ref_en(fixed_ref_en), .main_rail_en(main_rail_en),
  .term_rail_en(term_rail_en), .track_dis_en(track_dis_en),
  .main_pd_en(main_pd_en), .sense_src_en(sense_src_en),
  .ref_code(ref_code), .high_side_on(high_side_on),
  .rail_good_oe(rail_good_oe));

// *** tb/mrs_seq_properties.sv ***
// Checker for the rail state sequencer top ports
// Assumes core_clk and active-low rst_b of the sequencer
module mrs_seq_properties (
  // Clock and reset
  input wire logic                      core_clk,
  input wire logic                      rst_b,
  // Pins and comparators
  input wire logic                      suspend_select,
  input wire logic                      power_on_select,
  input wire logic                      in_win8,
  input wire logic                      in_win16,
  input wire logic                      fb_below_ref,
  // Enables and status
  input wire logic                      fixed_ref_en,
  input wire logic                      main_rail_en,
  input wire logic                      term_rail_en,
  input wire logic                      track_dis_en,
  input wire logic                      main_pd_en,
  input wire logic                      sense_src_en,
  input wire logic [mrs_pkg::REF_W-1:0] ref_code,
  input wire logic                      high_side_on,
  input wire logic                      rail_good_oe
);
  int hold_q, ramp_q, win_q, ref_q, trk_q;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  // Run lengths of the watched levels
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hold_q <= 0;
      ramp_q <= 0;
      win_q  <= 0;
      ref_q  <= 0;
      trk_q  <= 0;
    end
    else
    begin
      hold_q <= sense_src_en ? hold_q + 1 : 0;
      ramp_q <= main_rail_en ? ramp_q + 1 : 0;
      win_q  <= in_win8 ? win_q + 1 : 0;
      ref_q  <= fixed_ref_en ? ref_q + 1 : 0;
      trk_q  <= track_dis_en ? trk_q + 1 : 0;
    end
  end

  full_on_a: assert property (
    (power_on_select && suspend_select)[*3] |->
      fixed_ref_en && term_rail_en) else $error("full on enables low");
  float_term_a: assert property (
    (!suspend_select)[*3] |-> !term_rail_en)
    else $error("termination rail not floated");
  off_dark_a: assert property (
    (!power_on_select)[*3] |-> !fixed_ref_en && !main_rail_en &&
      !term_rail_en) else $error("rail left on while off");
  holdoff_len_a: assert property (
    $rose(main_rail_en) |-> hold_q inside {[3990:4010]})
    else $error("hold-off length wrong");
  ramp_len_a: assert property (
    $rose(ref_code == mrs_pkg::REF_FULL) |-> ramp_q inside {[6990:7010]})
    else $error("ramp length wrong");
  good_delay_a: assert property (
    $fell(rail_good_oe) |-> win_q >= 9990 && ref_q >= 20990)
    else $error("rail good too early");
  bad_drop_a: assert property (
    ($fell(in_win16) && !rail_good_oe) |-> ##[1:8] rail_good_oe)
    else $error("rail good not dropped");
  track_path_a: assert property (
    track_dis_en |-> !main_pd_en && !main_rail_en)
    else $error("tracking mixed with pull-down");
  track_len_a: assert property (
    ($fell(track_dis_en) && main_pd_en) |-> trk_q inside {[39990:40010]})
    else $error("tracking span wrong");
  set_req_a: assert property (
    (fb_below_ref[*4] ##0 (ref_code == mrs_pkg::REF_FULL)) |->
      ##[0:260] high_side_on) else $error("no set request");

  cover property ($fell(rail_good_oe));
  cover property ($rose(main_pd_en));
  cover property ($rose(high_side_on));
endmodule
